// ===== host_port_pkg.sv
// Constants and types shared by the dual serial host port
package host_port_pkg;

    // Serial command bytes and slave address
    localparam logic [7:0] SPI_CMD_WRITE = 8'hd4;
    localparam logic [7:0] SPI_CMD_READ  = 8'hd5;
    localparam logic [6:0] DEV_ADDR_BASE = 7'h2a;

    // Counts
    localparam logic [1:0] SS_LAST_PULSE = 2'h2;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [2:0] LAST_BIT      = 3'h7;
    localparam logic [1:0] BYTE_DATA     = 2'h2;

    // Lanes of the synchroniser words
    localparam int SY_SCL = 0;
    localparam int SY_SDA = 1;
    localparam int SY_SS  = 2;
    localparam int SY_TOG = 3;

    // Idle levels per lane: clock, data and select high, toggle low
    localparam logic [3:0] SYNC_IDLE = 4'h7;

    typedef enum logic [1:0] {EV_SUB, EV_WRITE, EV_READ_NEXT} link_ev_kind_t;

    typedef enum logic [2:0] {
        I_IDLE, I_RECV, I_ACK, I_SEND, I_MACK, I_NEXT
    } i2c_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
        logic       we;
    } reg_write_t;

    typedef struct packed {
        logic       lrst;
        logic [3:0] sy1;
        logic [3:0] sy2;
        logic [3:0] sy3;
        logic       spi;
        logic [1:0] ss_cnt;
        i2c_state_t state;
        logic [3:0] cnt;
        logic [1:0] byte_no;
        logic       rw;
        logic [7:0] sh;
        logic       drive_low;
        logic [7:0] addr;
        logic       over;
        reg_write_t wr;
        logic [7:0] rd_byte;
    } sys_state_t;

    typedef struct packed {
        logic [2:0] cnt;
        logic [1:0] byte_no;
        logic       is_rd;
        logic       is_wr;
        logic [7:0] sh;
    } link_frame_t;

    typedef struct packed {
        logic          tog;
        link_ev_kind_t kind;
        logic [7:0]    data;
    } link_event_t;

    typedef struct packed {
        logic [7:0] sh;
        logic       drive;
    } link_out_t;

    // Synchronisers start at idle levels, so no false edge follows reset
    localparam sys_state_t SYS_RESET = '{lrst: 1'b1, state: I_IDLE,
                                         sy1: SYNC_IDLE, sy2: SYNC_IDLE,
                                         sy3: SYNC_IDLE, default: '0};

endpackage

// ===== dual_serial_host_port.sv
// Dual two-wire / four-wire serial host port of the video encoder
// Summary of operation
// - After reset the port works as a two-wire open-drain slave.
// - Three low pulses on select pin; third rising edge enters SPI mode.
// - SPI mode holds until hardware reset; no bus sequence leaves it.
// - In two-wire mode the data line is only pulled low or released.
// - First byte after start: 7-bit address, direction in LSB, 1 read.
// - Address select bit of the slave address follows the select pin.
// - Data falling while clock high is a start; transfer begins.
// - Bits arrive MSB first; matching address acknowledged on ninth pulse.
// - Address mismatch: release the bus, idle, wait for next start.
// - First byte is device address, second the starting subaddress.
// - Each further data byte advances the subaddress by one, up to the top register.
// - Start or stop out of sequence abandons the transfer at once.
// - Nonexistent subaddress: no acknowledge, return to idle.
// - Reads past the top keep returning the top register until no-ack.
// - Writes past the top are dropped, not acknowledged, port idles.
// - SPI frame opens with select low; first byte write command.
// - SPI input MSB first on rising clock; second byte is subaddress.
// - SPI write data follows subaddress; select high ends the frame.
// - Read frame opens with read command; device then returns data.
// - SPI read data leaves MSB first, changing on falling clock.
`timescale 1ns/1ps
`default_nettype none

module dual_serial_host_port
    import host_port_pkg::*;
#(
    parameter logic [7:0] LAST_SUBADDR = 8'h7f
) (
    input  wire logic       clock,
    input  wire logic       reset,
    input  wire logic       link_clock,
    input  wire logic       clk_mosi_pin,
    input  wire logic       data_pin_in,
    output logic            data_pin_out,
    output logic            data_pin_oe_n,
    input  wire logic       addr_bit_or_slave_select_pin,
    output logic            lock_input_or_serial_out_pin_out,
    output logic            lock_input_or_serial_out_pin_oe_n,
    output logic [7:0]      reg_addr,
    input  wire logic [7:0] reg_rd_data,
    output reg_write_t      reg_write,
    output logic            spi_mode
);

    sys_state_t  st_ff;
    sys_state_t  nxt_st;
    link_frame_t lf_ff;
    link_frame_t nxt_lf;
    link_event_t le_ff;
    link_event_t nxt_le;
    link_out_t   lo_ff;
    link_out_t   nxt_lo;

    logic       scl_hi;
    logic       scl_rise;
    logic       scl_fall;
    logic       i2c_start;
    logic       i2c_stop;
    logic       ss_rise;
    logic       link_ev;
    logic       byte_done;
    logic [6:0] dev_addr;
    logic       frame_clr;
    logic       link_rst;

    // Subaddress step that stops at the top register
    function automatic logic [7:0] sat_inc(input logic [7:0] a);
        sat_inc = (a == LAST_SUBADDR) ? a : a + 8'h01;
    endfunction

    // Subaddress step after a write, flagging a pass beyond the top
    function automatic logic [8:0] write_step(input logic [7:0] a);
        write_step = {a == LAST_SUBADDR, sat_inc(a)};
    endfunction

    // Edge and condition decode on the second synchroniser stage
    assign scl_hi    = st_ff.sy2[SY_SCL] & st_ff.sy3[SY_SCL];
    assign scl_rise  = st_ff.sy2[SY_SCL] & ~st_ff.sy3[SY_SCL];
    assign scl_fall  = ~st_ff.sy2[SY_SCL] & st_ff.sy3[SY_SCL];
    assign i2c_start = scl_hi & st_ff.sy3[SY_SDA] & ~st_ff.sy2[SY_SDA];
    assign i2c_stop  = scl_hi & ~st_ff.sy3[SY_SDA] & st_ff.sy2[SY_SDA];
    assign ss_rise   = st_ff.sy2[SY_SS] & ~st_ff.sy3[SY_SS];
    assign link_ev   = st_ff.sy2[SY_TOG] ^ st_ff.sy3[SY_TOG];
    assign dev_addr  = {DEV_ADDR_BASE[6:1], st_ff.sy2[SY_SS]};
    assign byte_done = ~st_ff.spi & ~i2c_start & ~i2c_stop
                     & (st_ff.state == I_RECV) & scl_fall
                     & (st_ff.cnt == BITS_PER_BYTE);

    // System-side next state: mode switch, two-wire slave, SPI events
    always_comb begin
        nxt_st         = st_ff;
        nxt_st.lrst    = 1'b0;
        nxt_st.wr.we   = 1'b0;
        nxt_st.sy1     = {le_ff.tog, addr_bit_or_slave_select_pin,
                          data_pin_in, clk_mosi_pin};
        nxt_st.sy2     = st_ff.sy1;
        nxt_st.sy3     = st_ff.sy2;
        // Read data only moves when the subaddress moves
        nxt_st.rd_byte = reg_rd_data;

        // Select pulses counted only while still in two-wire mode
        if (!st_ff.spi && ss_rise) begin
            if (st_ff.ss_cnt == SS_LAST_PULSE) begin
                nxt_st.spi = 1'b1;
            end else begin
                nxt_st.ss_cnt = st_ff.ss_cnt + 2'h1;
            end
        end

        if (st_ff.spi) begin
            // Two-wire machine parked; data pin is now the SPI clock
            nxt_st.state     = I_IDLE;
            nxt_st.drive_low = 1'b0;
            if (link_ev) begin
                unique case (le_ff.kind)
                    EV_SUB: begin
                        nxt_st.addr = le_ff.data;
                        nxt_st.over = le_ff.data > LAST_SUBADDR;
                    end
                    EV_WRITE: begin
                        if (!st_ff.over) begin
                            nxt_st.wr = '{addr: st_ff.addr,
                                          data: le_ff.data, we: 1'b1};
                            {nxt_st.over, nxt_st.addr} = write_step(st_ff.addr);
                        end
                    end
                    EV_READ_NEXT: nxt_st.addr = sat_inc(st_ff.addr);
                    default: ;
                endcase
            end
        end else if (i2c_start) begin
            // Restart anywhere reopens the address phase
            nxt_st.state     = I_RECV;
            nxt_st.cnt       = 4'h0;
            nxt_st.byte_no   = 2'h0;
            nxt_st.rw        = 1'b0;
            nxt_st.drive_low = 1'b0;
        end else if (i2c_stop) begin
            nxt_st.state     = I_IDLE;
            nxt_st.drive_low = 1'b0;
        end else begin
            unique case (st_ff.state)
                I_IDLE: ;
                I_RECV: begin
                    if (scl_rise && st_ff.cnt != BITS_PER_BYTE) begin
                        nxt_st.sh  = {st_ff.sh[6:0], st_ff.sy2[SY_SDA]};
                        nxt_st.cnt = st_ff.cnt + 4'h1;
                    end else if (byte_done) begin
                        nxt_st.state     = I_ACK;
                        nxt_st.drive_low = 1'b1;
                        unique case (st_ff.byte_no)
                            2'h0: begin
                                if (st_ff.sh[7:1] == dev_addr) begin
                                    nxt_st.rw = st_ff.sh[0];
                                end else begin
                                    nxt_st.state     = I_IDLE;
                                    nxt_st.drive_low = 1'b0;
                                end
                            end
                            2'h1: begin
                                if (st_ff.sh > LAST_SUBADDR) begin
                                    nxt_st.state     = I_IDLE;
                                    nxt_st.drive_low = 1'b0;
                                end else begin
                                    nxt_st.addr = st_ff.sh;
                                    nxt_st.over = 1'b0;
                                end
                            end
                            default: begin
                                if (st_ff.over) begin
                                    nxt_st.state     = I_IDLE;
                                    nxt_st.drive_low = 1'b0;
                                end else begin
                                    nxt_st.wr = '{addr: st_ff.addr,
                                                  data: st_ff.sh,
                                                  we: 1'b1};
                                    {nxt_st.over, nxt_st.addr} =
                                        write_step(st_ff.addr);
                                end
                            end
                        endcase
                    end
                end
                I_ACK: begin
                    // Ack held through the ninth clock, dropped on its fall
                    if (scl_fall) begin
                        nxt_st.cnt     = 4'h0;
                        nxt_st.byte_no = (st_ff.byte_no == BYTE_DATA) ?
                                         BYTE_DATA : st_ff.byte_no + 2'h1;
                        if (st_ff.rw) begin
                            nxt_st.state     = I_SEND;
                            nxt_st.sh        = st_ff.rd_byte;
                            nxt_st.drive_low = ~st_ff.rd_byte[7];
                        end else begin
                            nxt_st.state     = I_RECV;
                            nxt_st.drive_low = 1'b0;
                        end
                    end
                end
                I_SEND: begin
                    if (scl_rise) begin
                        nxt_st.cnt = st_ff.cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (st_ff.cnt == BITS_PER_BYTE) begin
                            nxt_st.state     = I_MACK;
                            nxt_st.drive_low = 1'b0;
                        end else begin
                            nxt_st.sh        = {st_ff.sh[6:0], 1'b0};
                            nxt_st.drive_low = ~st_ff.sh[6];
                        end
                    end
                end
                I_MACK: begin
                    // Master no-ack ends the read
                    if (scl_rise) begin
                        if (st_ff.sy2[SY_SDA]) begin
                            nxt_st.state = I_IDLE;
                        end else begin
                            nxt_st.state = I_NEXT;
                            nxt_st.addr  = sat_inc(st_ff.addr);
                        end
                    end
                end
                I_NEXT: begin
                    // Clock high lasts long enough for the new fetch
                    if (scl_fall) begin
                        nxt_st.state     = I_SEND;
                        nxt_st.cnt       = 4'h0;
                        nxt_st.sh        = st_ff.rd_byte;
                        nxt_st.drive_low = ~st_ff.rd_byte[7];
                    end
                end
                default: nxt_st.state = I_IDLE;
            endcase
        end
    end

    // System-side state register
    always_ff @(posedge clock) begin
        if (reset) begin
            st_ff <= SYS_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Link side: frame state cleared while select is high
    assign frame_clr = addr_bit_or_slave_select_pin | st_ff.lrst;
    assign link_rst  = st_ff.lrst;

    // Link side next state on rising serial clock
    always_comb begin
        nxt_lf     = lf_ff;
        nxt_le     = le_ff;
        nxt_lf.sh  = {lf_ff.sh[6:0], clk_mosi_pin};
        nxt_lf.cnt = lf_ff.cnt + 3'h1;
        // First bit of each read byte frees the system to fetch the next
        if (lf_ff.is_rd && lf_ff.byte_no != 2'h0 && lf_ff.cnt == 3'h0) begin
            nxt_le.tog  = ~le_ff.tog;
            nxt_le.kind = EV_READ_NEXT;
        end
        if (lf_ff.cnt == LAST_BIT) begin
            nxt_lf.byte_no = (lf_ff.byte_no == BYTE_DATA) ?
                             BYTE_DATA : lf_ff.byte_no + 2'h1;
            if (lf_ff.byte_no == 2'h0) begin
                nxt_lf.is_wr = nxt_lf.sh == SPI_CMD_WRITE;
                nxt_lf.is_rd = nxt_lf.sh == SPI_CMD_READ;
            end else if (lf_ff.is_wr) begin
                nxt_le.tog  = ~le_ff.tog;
                nxt_le.kind = (lf_ff.byte_no == 2'h1) ? EV_SUB : EV_WRITE;
                nxt_le.data = nxt_lf.sh;
            end
        end
    end

    // Frame counters; unknown commands leave the frame inert
    always_ff @(posedge link_clock or posedge frame_clr) begin
        if (frame_clr) begin
            lf_ff <= '0;
        end else begin
            lf_ff <= nxt_lf;
        end
    end

    // Event word; toggle plus bundled data, stable for a whole byte
    always_ff @(posedge link_clock or posedge link_rst) begin
        if (link_rst) begin
            le_ff <= '0;
        end else begin
            le_ff <= nxt_le;
        end
    end

    // Read data shifter; the prefetched byte is quasi-static here
    always_comb begin
        nxt_lo = lo_ff;
        if (lf_ff.is_rd && lf_ff.byte_no != 2'h0) begin
            nxt_lo.drive = 1'b1;
            if (lf_ff.cnt == 3'h0) begin
                nxt_lo.sh = st_ff.rd_byte;
            end else begin
                nxt_lo.sh = {lo_ff.sh[6:0], 1'b0};
            end
        end
    end

    // Output changes on the falling serial clock
    always_ff @(negedge link_clock or posedge frame_clr) begin
        if (frame_clr) begin
            lo_ff <= '0;
        end else begin
            lo_ff <= nxt_lo;
        end
    end

    // Pins and register-file side
    assign data_pin_out                      = 1'b0;
    assign data_pin_oe_n                     = ~st_ff.drive_low;
    assign lock_input_or_serial_out_pin_out  = lo_ff.sh[7];
    assign lock_input_or_serial_out_pin_oe_n = ~(lo_ff.drive & st_ff.spi);
    assign reg_addr                          = st_ff.addr;
    assign reg_write                         = st_ff.wr;
    assign spi_mode                          = st_ff.spi;

    // Mode handling
    mode_reset_a: assert property (@(posedge clock) reset |=> !spi_mode)
        else $error("port not in two-wire mode after reset");
    mode_enter_a: assert property (@(posedge clock) disable iff (reset)
        (!spi_mode && ss_rise && st_ff.ss_cnt == SS_LAST_PULSE) |=> spi_mode)
        else $error("third select pulse did not enter SPI mode");
    mode_early_a: assert property (@(posedge clock) disable iff (reset)
        (!spi_mode && st_ff.ss_cnt != SS_LAST_PULSE) |=> !spi_mode)
        else $error("SPI mode entered before third select pulse");
    spi_sticky_a: assert property (@(posedge clock) disable iff (reset)
        spi_mode |=> spi_mode)
        else $error("SPI mode left without reset");

    // Two-wire slave behaviour
    open_drain_a: assert property (@(posedge clock) disable iff (reset)
        !data_pin_oe_n |-> (!spi_mode && st_ff.state inside {I_ACK, I_SEND}))
        else $error("data pin driven outside ack or send");
    start_seen_a: assert property (@(posedge clock) disable iff (reset)
        (i2c_start && !spi_mode) |=> (st_ff.state == I_RECV && st_ff.cnt == 0))
        else $error("start condition not taken");
    stop_idle_a: assert property (@(posedge clock) disable iff (reset)
        (i2c_stop && !spi_mode) |=> (st_ff.state == I_IDLE && data_pin_oe_n))
        else $error("stop did not return to idle");
    addr_ack_a: assert property (@(posedge clock) disable iff (reset)
        (byte_done && st_ff.byte_no == 0 && st_ff.sh[7:1] == dev_addr)
        |=> !data_pin_oe_n ##1 (!data_pin_oe_n || st_ff.state == I_ACK))
        else $error("matching address not acknowledged");
    addr_miss_a: assert property (@(posedge clock) disable iff (reset)
        (byte_done && st_ff.byte_no == 0 && st_ff.sh[7:1] != dev_addr)
        |=> (st_ff.state == I_IDLE && data_pin_oe_n))
        else $error("foreign address not ignored");
    bad_sub_a: assert property (@(posedge clock) disable iff (reset)
        (byte_done && st_ff.byte_no == 1 && st_ff.sh > LAST_SUBADDR)
        |=> (st_ff.state == I_IDLE && data_pin_oe_n))
        else $error("invalid subaddress acknowledged");
    over_write_a: assert property (@(posedge clock) disable iff (reset)
        (byte_done && st_ff.byte_no == BYTE_DATA && st_ff.over)
        |=> (!reg_write.we && st_ff.state == I_IDLE && data_pin_oe_n))
        else $error("write past top register not refused");
    write_step_a: assert property (@(posedge clock) disable iff (reset)
        reg_write.we |-> reg_addr == sat_inc(reg_write.addr))
        else $error("subaddress did not advance after write");
    miso_quiet_a: assert property (@(posedge clock) disable iff (reset)
        !spi_mode |-> lock_input_or_serial_out_pin_oe_n)
        else $error("serial output driven in two-wire mode");

    // Main scenarios
    spi_entry_c: cover property (@(posedge clock) disable iff (reset)
        !spi_mode ##1 spi_mode);
    i2c_write_c: cover property (@(posedge clock) disable iff (reset)
        reg_write.we && !spi_mode);
    i2c_read_c: cover property (@(posedge clock) disable iff (reset)
        st_ff.state == I_MACK ##[1:200] st_ff.state == I_NEXT);
    spi_write_c: cover property (@(posedge clock) disable iff (reset)
        reg_write.we && spi_mode);

endmodule

`default_nettype wire

// ===== serial_master_model.sv
// Behavioural two-wire and four-wire bus master for the host port
`timescale 1ns/1ps
`default_nettype none

module serial_master_model (
    output logic      scl_mosi,
    output logic      pull_low,
    output logic      select_n,
    input  wire logic sda,
    input  wire logic miso
);
    // Idle: lines released, select high so the address bit reads 1
    initial begin
        scl_mosi = 1'b1;
        pull_low = 1'b0;
        select_n = 1'b1;
    end

    // Data moves only while clock is low, so no stray start or stop
    task automatic bit_io(input logic b, output logic r);
        #20 pull_low = ~b;
        #80 scl_mosi = 1'b1;
        #50 r = sda;
        #50 scl_mosi = 1'b0;
    endtask

    // Start from idle, or repeated start with clock low
    task automatic start();
        #20 pull_low = 1'b0;
        #80 scl_mosi = 1'b1;
        #100 pull_low = 1'b1;
        #100 scl_mosi = 1'b0;
    endtask

    task automatic stop();
        #20 pull_low = 1'b1;
        #80 scl_mosi = 1'b1;
        #100 pull_low = 1'b0;
        #100;
    endtask

    // Byte out MSB first; nak is the ninth-bit level
    task automatic put(input logic [7:0] b, output logic nak);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(b[i], r);
        bit_io(1'b1, nak);
    endtask

    // Byte in; the last one is answered with no ack
    task automatic get(input logic last, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
        bit_io(last, r);
    endtask

    // Select low pulses while both two-wire lines rest high
    task automatic pulses(input int n);
        repeat (n) begin
            #100 select_n = 1'b0;
            #100 select_n = 1'b1;
        end
    endtask

    // Serial clock then rests low, since it shares the data wire
    task automatic sclk_low();
        #100 pull_low = 1'b1;
    endtask

    // MOSI set with clock low, sampled on its rise at 30 ns per bit
    task automatic frame(input logic [7:0] b[$], output logic [7:0] r[$]);
        logic [7:0] i;
        r = {};
        #40 select_n = 1'b0;
        foreach (b[k]) begin
            for (int n = 7; n >= 0; n--) begin
                scl_mosi = b[k][n];
                #15 pull_low = 1'b0;
                i[n] = miso;
                #15 pull_low = 1'b1;
            end
            r.push_back(i);
        end
        #40 select_n = 1'b1;
        #100;
    endtask
endmodule

`default_nettype wire

// ===== dual_serial_host_port_bench.sv
// Self-checking bench for the dual serial host port
`timescale 1ns/1ps
`default_nettype none

module dual_serial_host_port_bench;
    import host_port_pkg::*;
    logic       clock = 1'b0;
    logic       reset = 1'b1;
    logic       scl_mosi, pull_low, select_n, sda, miso;
    logic       oe_n, out, miso_out, miso_oe_n, spi_mode;
    logic [7:0] reg_addr;
    reg_write_t reg_write;
    reg_write_t exp_q[$];
    int         fails = 0;
    int         compares = 0;

    // Pulled-up data wire; MISO floats when released
    assign sda  = (pull_low || (!oe_n && !out)) ? 1'b0 : 1'b1;
    assign miso = miso_oe_n ? 1'bz : miso_out;
    always #5 clock = ~clock;

    serial_master_model u_serial_master_model (.scl_mosi(scl_mosi),
        .pull_low(pull_low), .select_n(select_n), .sda(sda), .miso(miso));

    // Register file answers with a fixed pattern of its address
    dual_serial_host_port u_dual_serial_host_port (.clock(clock),
        .reset(reset), .link_clock(sda), .clk_mosi_pin(scl_mosi),
        .data_pin_in(sda), .data_pin_out(out), .data_pin_oe_n(oe_n),
        .addr_bit_or_slave_select_pin(select_n),
        .lock_input_or_serial_out_pin_out(miso_out),
        .lock_input_or_serial_out_pin_oe_n(miso_oe_n),
        .reg_addr(reg_addr), .reg_rd_data(reg_addr ^ 8'h5a),
        .reg_write(reg_write), .spi_mode(spi_mode));

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic cmp_wr(input reg_write_t got, input reg_write_t exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t write %h want %h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Write pulses retire the oldest note; sampled mid-cycle where settled
    always @(negedge clock) begin
        if (oe_n === 1'b0) cmp(out, 8'h0);
        if (reg_write.we === 1'b1 && exp_q.size() == 0) cmp_wr(reg_write, '0);
        else if (reg_write.we === 1'b1) cmp_wr(reg_write, exp_q.pop_front());
    end

    // Watchdog well beyond the expected run of about 35 us
    initial begin
        #300000;
        fails++;
        report_and_stop();
    end

    initial begin
        logic       nak;
        logic [7:0] b, s;
        logic [7:0] w[5];
        logic [7:0] q[$];
        logic [7:0] r[$];
        void'($urandom(32'hfae5));
        repeat (10) @(posedge clock);
        #1 reset = 1'b0;
        repeat (5) @(posedge clock);
        #1;
        cmp(spi_mode, 8'h0);
        cmp(oe_n, 8'h1);
        $display("test reset done");
        u_serial_master_model.start();
        u_serial_master_model.put(8'h54, nak);
        cmp(nak, 8'h1);
        u_serial_master_model.stop();
        $display("test foreign address done");
        // Aborted transfer, then a write running past the top register
        foreach (w[k]) w[k] = 8'($urandom);
        w[0] = 8'h56;
        w[1] = 8'h7e;
        exp_q.push_back('{addr: 8'h7e, data: w[2], we: 1'b1});
        exp_q.push_back('{addr: 8'h7f, data: w[3], we: 1'b1});
        u_serial_master_model.start();
        u_serial_master_model.put(8'h56, nak);
        u_serial_master_model.put(8'h10, nak);
        repeat (3) u_serial_master_model.bit_io(1'b1, nak);
        u_serial_master_model.start();
        foreach (w[k]) begin
            u_serial_master_model.put(w[k], nak);
            cmp(nak, 8'(k == 4));
        end
        u_serial_master_model.stop();
        u_serial_master_model.start();
        u_serial_master_model.put(8'h56, nak);
        u_serial_master_model.put(8'h80, nak);
        cmp(nak, 8'h1);
        u_serial_master_model.stop();
        $display("test two-wire write done");
        u_serial_master_model.start();
        u_serial_master_model.put(8'h56, nak);
        u_serial_master_model.put(8'h7f, nak);
        u_serial_master_model.start();
        u_serial_master_model.put(8'h57, nak);
        cmp(nak, 8'h0);
        for (int k = 0; k < 2; k++) begin
            u_serial_master_model.get(k == 1, b);
            cmp(b, 8'h7f ^ 8'h5a);
        end
        u_serial_master_model.stop();
        $display("test two-wire read done");
        // Four-wire write then read back from a random subaddress
        u_serial_master_model.pulses(2);
        repeat (5) @(posedge clock);
        #1;
        cmp(spi_mode, 8'h0);
        u_serial_master_model.pulses(1);
        u_serial_master_model.sclk_low();
        repeat (5) @(posedge clock);
        #1;
        cmp(spi_mode, 8'h1);
        s = 8'($urandom_range(0, 125));
        exp_q.push_back('{addr: s, data: w[2], we: 1'b1});
        exp_q.push_back('{addr: s + 8'h1, data: w[3], we: 1'b1});
        q = {8'hd4, s, w[2], w[3]};
        u_serial_master_model.frame(q, r);
        // Unknown command: any write from this frame is unexpected
        q = {8'hd6, s, w[4]};
        u_serial_master_model.frame(q, r);
        q = {8'hd4, s};
        u_serial_master_model.frame(q, r);
        q = {8'hd5, 8'h0, 8'h0};
        u_serial_master_model.frame(q, r);
        cmp(r[1], s ^ 8'h5a);
        cmp(r[2], (s + 8'h1) ^ 8'h5a);
        cmp(miso_oe_n, 8'h1);
        cmp(spi_mode, 8'h1);
        cmp(8'(exp_q.size()), 8'h0);
        $display("test four-wire done");
        report_and_stop();
    end
endmodule

`default_nettype wire
